// ==== src/sclk_timing_core.sv ====
// Switching clock selection and primary/rectifier gate timing with a Wishbone register slave
// Operation
// R1 - Three clock modes: internal oscillator, external sync, primary-secondary via sync pin.
// R2 - Internal oscillator frequency is configurable between 100 kHz and 2 MHz.
// R3 - Without frequency resistor no internal switching; primaries wait for sync clock.
// R4 - Internal mode drives sync pin at twice the switching frequency.
// R5 - Sync output clock is phase aligned with the switching cycle.
// R6 - External source supplies twice-frequency clock, 200 kHz-4 MHz, 40-60% duty.
// R7 - External source should preferably use a 50% duty clock.
// R8 - External sync clock is inverted internally before use.
// R9 - Switching frequency in external mode is half the sync clock frequency.
// R10 - Secondary switches 90 or 270 degrees from primary, per synchronisation instant.
// R11 - Second primary output is active only with 50% duty limit.
// R12 - Second rectifier output is active only with 50% duty limit.
// R13 - Rectifier outputs stay off until soft-start level exceeds 1 V.
// R14 - Primary off, then programmable dead time, then rectifier on.
// R15 - Rectifier off, then separate programmable dead time, then primary on.
// R16 - Unconfigured dead time uses the 8 ns minimum.
// R17 - Dead-time setting in kilohms equals 1.207 times ns minus 8.858.
// R18 - Dead times apply only after soft start, when rectifiers are enabled.
// R19 - Current sense is ignored for a blanking interval after primary rises.
// R20 - Blanking setting in kilohms equals 1.212 times ns minus 9.484.
// R21 - Minimum primary on-time is blanking interval plus fixed logic delay.
// R22 - Primary turns on with switching clock, off when current trip asserts.
// R23 - Duty limit is three-valued: 100%, 75% or 50%.
// R24 - Dead and blanking times are whole timing-clock cycles, rounded up.
`include "sclk_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module sclk_timing_core
  import sclk_pkg::*;
(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SYNC_I,
  output logic SYNC_O,
  output logic SYNC_OE,
  input wire logic CS_TRIP_I,
  output logic PRIMARY_DRIVE_A,
  output logic PRIMARY_DRIVE_B,
  output logic RECT_DRIVE_A,
  output logic RECT_DRIVE_B
);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Kilohm setting to whole clock cycles, rounded up; never below one cycle
  function automatic logic [7:0] set_to_cyc(input logic [8:0] kohm, input int ofs_milli,
                                            input int gain_milli);
    int num;
    int den;
    int cyc;
    num = int'(kohm) * 1000 + ofs_milli;
    den = (gain_milli * `SCLK_CLK_PS) / 1000;
    cyc = (num + den - 1) / den;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[7:0];
  endfunction

  sclk_state_s s_r;
  sclk_state_s s_nxt;

  // Derived controls, recomputed from the registers every cycle
  logic rt_present;
  logic sr_en;
  sclk_duty_e duty;
  logic [7:0] ps_cyc;
  logic [7:0] sp_cyc;
  logic [7:0] min_on_cyc;
  logic [9:0] half_lim;

  always_comb begin
    rt_present = s_r.ctrl[`SCLK_CTRL_RT_BIT];
    sr_en = s_r.ctrl[`SCLK_CTRL_SR_BIT];
    case (s_r.ctrl[`SCLK_CTRL_DCL_HI:`SCLK_CTRL_DCL_LO])
      2'b00: duty = DUTY_50; // [R23]
      2'b01: duty = DUTY_75; // [R23]
      default: duty = DUTY_100; // [R23]
    endcase
    // Zero setting means an open pin: fall back to the minimum dead time
    if (s_r.ps_set == 9'h000) begin
      ps_cyc = 8'(`SCLK_MIN_DEAD_CYC); // [R16]
    end else begin
      ps_cyc = set_to_cyc(s_r.ps_set, `SCLK_DT_OFS_MILLI, `SCLK_DT_GAIN_MILLI); // [R17] [R24]
    end
    if (s_r.sp_set == 9'h000) begin
      sp_cyc = 8'(`SCLK_MIN_DEAD_CYC); // [R16]
    end else begin
      sp_cyc = set_to_cyc(s_r.sp_set, `SCLK_DT_OFS_MILLI, `SCLK_DT_GAIN_MILLI); // [R17] [R24]
    end
    // Blanking plus logic delay forms the shortest pulse
    min_on_cyc = set_to_cyc(s_r.blank_set, `SCLK_LEB_OFS_MILLI, `SCLK_LEB_GAIN_MILLI)
                 + 8'(`SCLK_LOGIC_DELAY_CYC); // [R20] [R21] [R24]
    // Clamp the half period so the switching rate stays within its range
    if (s_r.sync_half < 10'(`SCLK_HALF_MIN_CYC)) begin
      half_lim = 10'(`SCLK_HALF_MIN_CYC); // [R2]
    end else if (s_r.sync_half > 10'(`SCLK_HALF_MAX_CYC)) begin
      half_lim = 10'(`SCLK_HALF_MAX_CYC); // [R2]
    end else begin
      half_lim = s_r.sync_half; // [R2]
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    logic req;
    logic sync_rise;
    logic sync_fall;
    logic tick;
    logic clk_ok;
    logic [1:0] q_new;
    logic en;
    logic start;
    logic max_end;
    logic trip;
    logic [31:0] wr;
    s_nxt = s_r;
    req = WB_CYC_I && WB_STB_I && !s_r.ack;
    tick = 1'b0;
    clk_ok = 1'b0;
    q_new = s_r.q;
    en = 1'b0;
    start = 1'b0;
    max_end = 1'b0;
    wr = 32'h0000_0000;
    sync_rise = 1'b0;
    sync_fall = 1'b0;
    trip = 1'b0;

    // Bus slave: ack one cycle after the request, dropped the next cycle
    s_nxt.ack = req;
    if (req && WB_WE_I) begin
      case (WB_ADR_I)
        `SCLK_ADR_CTRL: begin
          wr = sel_merge({28'h0000000, s_r.ctrl}, WB_DAT_I, WB_SEL_I);
          s_nxt.ctrl = wr[3:0];
        end
        `SCLK_ADR_SYNC_HALF: begin
          wr = sel_merge({22'h000000, s_r.sync_half}, WB_DAT_I, WB_SEL_I);
          s_nxt.sync_half = wr[9:0];
        end
        `SCLK_ADR_DEAD: begin
          wr = sel_merge({7'h00, s_r.sp_set, 7'h00, s_r.ps_set}, WB_DAT_I, WB_SEL_I);
          s_nxt.ps_set = wr[`SCLK_DEAD_PS_HI:`SCLK_DEAD_PS_LO];
          s_nxt.sp_set = wr[`SCLK_DEAD_SP_HI:`SCLK_DEAD_SP_LO];
        end
        `SCLK_ADR_BLANK: begin
          wr = sel_merge({23'h000000, s_r.blank_set}, WB_DAT_I, WB_SEL_I);
          s_nxt.blank_set = wr[8:0];
        end
        default: begin
          wr = 32'h0000_0000; // Status and unmapped writes are ignored
        end
      endcase
    end
    // Read data is latched with the ack; unmapped offsets read zero
    if (req) begin
      case (WB_ADR_I)
        `SCLK_ADR_CTRL: s_nxt.dat = {28'h0000000, s_r.ctrl};
        `SCLK_ADR_SYNC_HALF: s_nxt.dat = {22'h000000, s_r.sync_half};
        `SCLK_ADR_DEAD: s_nxt.dat = {7'h00, s_r.sp_set, 7'h00, s_r.ps_set};
        `SCLK_ADR_BLANK: s_nxt.dat = {23'h000000, s_r.blank_set};
        `SCLK_ADR_STATUS: s_nxt.dat = {16'h0000, 1'b0, s_r.ch[1].st, 1'b0, s_r.ch[0].st,
                                       s_r.ch[1].rect, s_r.ch[0].rect, s_r.ch[1].pri,
                                       s_r.ch[0].pri, s_r.q, s_r.present, !rt_present};
        default: s_nxt.dat = 32'h0000_0000;
      endcase
    end else begin
      s_nxt.dat = 32'h0000_0000;
    end

    // Two-flop synchronisers; the third flop only serves edge detection
    s_nxt.s1 = SYNC_I;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.c1 = CS_TRIP_I;
    s_nxt.c2 = s_r.c1;
    sync_rise = s_r.s2 && !s_r.s3;
    sync_fall = !s_r.s2 && s_r.s3;
    trip = s_r.c2;

    // Clock source selection by resistor presence and sync pin use
    if (rt_present) begin
      // Internal oscillator: sync pin is an output toggling every half period
      clk_ok = 1'b1; // [R1]
      s_nxt.present = 1'b0;
      s_nxt.loss_cnt = 12'h000;
      if (s_r.half_cnt >= half_lim - 10'h001) begin
        s_nxt.half_cnt = 10'h000;
        s_nxt.sync_out = !s_r.sync_out; // [R4]
        tick = 1'b1;
        q_new = s_r.q + 2'h1; // Rising sync edge lands on q0 or q2 [R5]
      end else begin
        s_nxt.half_cnt = s_r.half_cnt + 10'h001;
      end
    end else begin
      // External or secondary: sync pin is an input, no internal switching
      s_nxt.half_cnt = 10'h000;
      s_nxt.sync_out = 1'b0; // [R3]
      if (sync_rise || sync_fall) begin
        s_nxt.loss_cnt = 12'h000;
        s_nxt.present = 1'b1;
      end else if (s_r.loss_cnt >= 12'(`SCLK_SYNC_LOSS_CYC)) begin
        s_nxt.present = 1'b0; // Clock gone: stop switching [R3]
      end else begin
        s_nxt.loss_cnt = s_r.loss_cnt + 12'h001;
      end
      clk_ok = s_r.present; // [R1] [R3]
      // Inverted clock: a falling sync edge is a rising internal edge
      if (sync_fall) begin
        tick = 1'b1;
        q_new = (s_r.q == 2'h1) ? 2'h2 : 2'h0; // [R8] [R10]
      end else if (sync_rise) begin
        tick = 1'b1;
        q_new = s_r.q + 2'h1; // Four edges per switching cycle [R9]
      end
    end
    s_nxt.q = q_new;

    // Channel sequencing: channel 0 drives the A pair, channel 1 the B pair
    for (int i = 0; i < 2; i++) begin
      if (i == 0) begin
        en = clk_ok;
        start = tick && (q_new == 2'h0); // [R22]
        case (duty)
          DUTY_50: max_end = tick && (q_new == 2'h2); // [R23]
          DUTY_75: max_end = tick && (q_new == 2'h3); // [R23]
          default: max_end = 1'b0; // [R23]
        endcase
      end else begin
        en = clk_ok && (duty == DUTY_50); // [R11] [R12]
        start = tick && (q_new == 2'h2); // [R22]
        max_end = tick && (q_new == 2'h0);
      end
      if (!en) begin
        s_nxt.ch[i].st = CH_IDLE; // [R11] [R12] [R3]
        s_nxt.ch[i].cnt = 8'h00;
        s_nxt.ch[i].pri = 1'b0;
        s_nxt.ch[i].rect = 1'b0;
      end else begin
        case (s_r.ch[i].st)
          CH_IDLE, CH_PS_WAIT: begin
            if (start) begin
              // Rectifier already off: primary may rise at once
              s_nxt.ch[i].st = CH_ON;
              s_nxt.ch[i].pri = 1'b1; // [R22]
              s_nxt.ch[i].cnt = min_on_cyc; // [R19]
            end else if (s_r.ch[i].st == CH_PS_WAIT) begin
              if (!sr_en) begin
                s_nxt.ch[i].st = CH_IDLE; // [R18]
              end else if (s_r.ch[i].cnt <= 8'h01) begin
                s_nxt.ch[i].st = CH_RECT;
                s_nxt.ch[i].rect = 1'b1; // [R14]
              end else begin
                s_nxt.ch[i].cnt = s_r.ch[i].cnt - 8'h01; // [R14]
              end
            end
          end
          CH_SP_WAIT: begin
            if (s_r.ch[i].cnt <= 8'h01) begin
              s_nxt.ch[i].st = CH_ON;
              s_nxt.ch[i].pri = 1'b1; // [R15]
              s_nxt.ch[i].cnt = min_on_cyc; // [R19]
            end else begin
              s_nxt.ch[i].cnt = s_r.ch[i].cnt - 8'h01; // [R15]
            end
          end
          CH_ON: begin
            // Duty limit ends the pulse first; trip counts only after blanking
            if (max_end || (s_r.ch[i].cnt == 8'h00 && trip)) begin
              s_nxt.ch[i].pri = 1'b0; // [R22] [R21]
              if (sr_en) begin
                s_nxt.ch[i].st = CH_PS_WAIT; // [R14] [R18]
                s_nxt.ch[i].cnt = ps_cyc;
              end else begin
                s_nxt.ch[i].st = CH_IDLE; // [R18]
              end
            end else if (start) begin
              s_nxt.ch[i].cnt = min_on_cyc; // Full duty: new cycle re-blanks [R19]
            end else if (s_r.ch[i].cnt != 8'h00) begin
              s_nxt.ch[i].cnt = s_r.ch[i].cnt - 8'h01; // [R19] [R21]
            end
          end
          CH_RECT: begin
            if (start) begin
              s_nxt.ch[i].rect = 1'b0;
              s_nxt.ch[i].st = CH_SP_WAIT; // [R15]
              s_nxt.ch[i].cnt = sp_cyc;
            end else if (!sr_en) begin
              s_nxt.ch[i].rect = 1'b0; // [R13]
              s_nxt.ch[i].st = CH_IDLE;
            end
          end
          default: begin
            s_nxt.ch[i].st = CH_IDLE;
            s_nxt.ch[i].pri = 1'b0;
            s_nxt.ch[i].rect = 1'b0;
          end
        endcase
      end
      // Rectifiers never drive during soft start
      if (!sr_en) begin
        s_nxt.ch[i].rect = 1'b0; // [R13]
      end
    end
  end

  // State register; reset values are constants only
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_r.ack <= 1'b0;
      s_r.dat <= 32'h0000_0000;
      s_r.ctrl <= `SCLK_CTRL_RST;
      s_r.sync_half <= `SCLK_SYNC_HALF_RST;
      s_r.ps_set <= `SCLK_DEAD_RST;
      s_r.sp_set <= `SCLK_DEAD_RST;
      s_r.blank_set <= `SCLK_BLANK_RST;
      s_r.s1 <= 1'b0;
      s_r.s2 <= 1'b0;
      s_r.s3 <= 1'b0;
      s_r.c1 <= 1'b0;
      s_r.c2 <= 1'b0;
      s_r.loss_cnt <= 12'h000;
      s_r.present <= 1'b0;
      s_r.half_cnt <= 10'h000;
      s_r.sync_out <= 1'b0;
      s_r.q <= 2'h3; // First internal-mode reference edge starts phase A
      for (int i = 0; i < 2; i++) begin
        s_r.ch[i].st <= CH_IDLE;
        s_r.ch[i].cnt <= 8'h00;
        s_r.ch[i].pri <= 1'b0;
        s_r.ch[i].rect <= 1'b0;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    WB_ACK_O = s_r.ack;
    WB_DAT_O = s_r.dat;
    SYNC_O = s_r.sync_out; // [R4] [R5]
    SYNC_OE = rt_present && s_r.ctrl[`SCLK_CTRL_RT_BIT]; // [R1]
    PRIMARY_DRIVE_A = s_r.ch[0].pri;
    PRIMARY_DRIVE_B = s_r.ch[1].pri; // [R11]
    RECT_DRIVE_A = s_r.ch[0].rect;
    RECT_DRIVE_B = s_r.ch[1].rect; // [R12]
  end

endmodule

`default_nettype wire

// ==== src/sclk_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the timing core
`ifndef SCLK_REGS_SVH
`define SCLK_REGS_SVH

// Register byte offsets (one aligned 32-bit word each)
`define SCLK_ADR_CTRL 8'h00
`define SCLK_ADR_SYNC_HALF 8'h04
`define SCLK_ADR_DEAD 8'h08
`define SCLK_ADR_BLANK 8'h0c
`define SCLK_ADR_STATUS 8'h10

// Control register fields
`define SCLK_CTRL_RT_BIT 0
`define SCLK_CTRL_DCL_LO 1
`define SCLK_CTRL_DCL_HI 2
`define SCLK_CTRL_SR_BIT 3

// Dead-time register fields (settings in kilohms)
`define SCLK_DEAD_PS_LO 0
`define SCLK_DEAD_PS_HI 8
`define SCLK_DEAD_SP_LO 16
`define SCLK_DEAD_SP_HI 24

// Reset values
`define SCLK_CTRL_RST 4'h5
`define SCLK_SYNC_HALF_RST 10'h0fa
`define SCLK_DEAD_RST 9'h000
`define SCLK_BLANK_RST 9'h00a

// Clock rate and printed times
`define SCLK_CLK_KHZ 200000
`define SCLK_CLK_PS 5000
`define SCLK_FSW_MIN_KHZ 100
`define SCLK_FSW_MAX_KHZ 2000
`define SCLK_MIN_DEAD_NS 8
`define SCLK_LOGIC_DELAY_NS 10
`define SCLK_SYNC_LOSS_NS 10000

// Setting-to-delay mapping: kilohms = gain * ns - offset, in thousandths
`define SCLK_DT_GAIN_MILLI 1207
`define SCLK_DT_OFS_MILLI 8858
`define SCLK_LEB_GAIN_MILLI 1212
`define SCLK_LEB_OFS_MILLI 9484

// Derived cycle counts
`define SCLK_MIN_DEAD_CYC ((`SCLK_MIN_DEAD_NS * 1000 + `SCLK_CLK_PS - 1) / `SCLK_CLK_PS)
`define SCLK_LOGIC_DELAY_CYC ((`SCLK_LOGIC_DELAY_NS * 1000 + `SCLK_CLK_PS - 1) / `SCLK_CLK_PS)
`define SCLK_SYNC_LOSS_CYC ((`SCLK_SYNC_LOSS_NS * 1000) / `SCLK_CLK_PS)
`define SCLK_HALF_MIN_CYC (`SCLK_CLK_KHZ / (4 * `SCLK_FSW_MAX_KHZ))
`define SCLK_HALF_MAX_CYC (`SCLK_CLK_KHZ / (4 * `SCLK_FSW_MIN_KHZ))

`endif

// ==== src/sclk_pkg.sv ====
// Types shared by the switching clock and gate timing core
package sclk_pkg;

  // Duty-limit selection: tied low, open, tied high
  typedef enum logic [1:0] {
    DUTY_50 = 2'b00,
    DUTY_75 = 2'b01,
    DUTY_100 = 2'b10
  } sclk_duty_e;

  // Per-channel drive sequence
  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_SP_WAIT = 3'b001,
    CH_ON = 3'b010,
    CH_PS_WAIT = 3'b011,
    CH_RECT = 3'b100
  } sclk_ch_e;

  typedef struct packed {
    sclk_ch_e st;
    logic [7:0] cnt;
    logic pri;
    logic rect;
  } sclk_chan_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [3:0] ctrl;
    logic [9:0] sync_half;
    logic [8:0] ps_set;
    logic [8:0] sp_set;
    logic [8:0] blank_set;
    logic s1;
    logic s2;
    logic s3;
    logic c1;
    logic c2;
    logic [11:0] loss_cnt;
    logic present;
    logic [9:0] half_cnt;
    logic sync_out;
    logic [1:0] q;
    sclk_chan_s [1:0] ch;
  } sclk_state_s;

endpackage

// ==== tb/sclk_timing_core_checker.sv ====
// Port-level property checker for the timing core
`include "sclk_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module sclk_timing_core_checker (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic SYNC_I,
  input wire logic SYNC_OE,
  input wire logic PRIMARY_DRIVE_A,
  input wire logic PRIMARY_DRIVE_B,
  input wire logic RECT_DRIVE_A,
  input wire logic RECT_DRIVE_B
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  logic [3:0] ctrl_r;
  logic [8:0] blank_r;
  logic [11:0] quiet_r;
  logic [11:0] idle_r;
  logic [9:0] on_r;
  logic si_r;
  logic wr;
  int min_on;
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I == 4'hf;
  // Shortest pulse: blanking rounded up plus the decision delay
  assign min_on = (int'(blank_r) * 1000 + 9484 + 6059) / 6060 + 2;
  // Settings shadowed at the write edge; counters saturate so they never wrap
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_r <= `SCLK_CTRL_RST;
      blank_r <= `SCLK_BLANK_RST;
      quiet_r <= 12'h000;
      idle_r <= 12'h000;
      on_r <= 10'h000;
      si_r <= 1'b0;
    end else begin
      if (wr && WB_ADR_I == `SCLK_ADR_CTRL) begin
        ctrl_r <= WB_DAT_I[3:0];
      end
      if (wr && WB_ADR_I == `SCLK_ADR_BLANK) begin
        blank_r <= WB_DAT_I[8:0];
      end
      quiet_r <= wr ? 12'h000 : quiet_r + {11'h000, ~&quiet_r};
      idle_r <= (SYNC_I != si_r) ? 12'h000 : idle_r + {11'h000, ~&idle_r};
      on_r <= PRIMARY_DRIVE_A ? on_r + {9'h000, ~&on_r} : 10'h000;
      si_r <= SYNC_I;
    end
  end
  chk_ack_pulse: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O)
    |=> WB_ACK_O ##1 !WB_ACK_O) else $error("bus answer is not a single pulse");
  chk_b_pair_off: assert property (
    (ctrl_r[2:1] != 2'b00 && $past(ctrl_r[2:1]) != 2'b00) |-> !PRIMARY_DRIVE_B && !RECT_DRIVE_B)
    else $error("second pair active without half duty limit");
  chk_rect_hold: assert property (
    (!ctrl_r[3] && !$past(ctrl_r[3])) |-> !RECT_DRIVE_A && !RECT_DRIVE_B)
    else $error("rectifier active while held off");
  chk_sync_dir: assert property (
    (ctrl_r[0] == $past(ctrl_r[0])) |-> SYNC_OE == ctrl_r[0])
    else $error("sync pin direction wrong for clock mode");
  chk_no_clock: assert property (
    (!ctrl_r[0] && idle_r > 12'h7da && quiet_r > 12'h7da) |-> !PRIMARY_DRIVE_A && !PRIMARY_DRIVE_B)
    else $error("primary switching without a sync clock");
  chk_no_overlap: assert property (
    !(PRIMARY_DRIVE_A && RECT_DRIVE_A) && !(PRIMARY_DRIVE_B && RECT_DRIVE_B))
    else $error("primary and rectifier on together");
  chk_ps_dead: assert property (
    $fell(PRIMARY_DRIVE_A) |-> !RECT_DRIVE_A [*2]) else $error("primary to rectifier gap short");
  chk_sp_dead: assert property (
    $fell(RECT_DRIVE_A) |-> !PRIMARY_DRIVE_A [*2]) else $error("rectifier to primary gap short");
  chk_min_on: assert property (
    ($fell(PRIMARY_DRIVE_A) && ctrl_r[2] && ctrl_r[0] && quiet_r > {2'b00, on_r}) |->
    on_r >= min_on)
    else $error("primary pulse shorter than minimum on time");
  cov_b_pair: cover property ($rose(PRIMARY_DRIVE_B));
  cov_rect: cover property ($rose(RECT_DRIVE_A));
  cov_ext: cover property (!SYNC_OE && $rose(PRIMARY_DRIVE_A));
endmodule
`default_nettype wire

// ==== tb/sclk_sync_source.sv ====
// External clock source standing on the far side of the sync pin
`timescale 1ns/100ps
`default_nettype none
module sclk_sync_source #(
  parameter real HALF_NS = 24.0
) (
  input wire logic run,
  output logic clk_o
);
  // Even-duty square wave; finishes its period, then stands low while idle
  initial begin
    clk_o = 1'b0;
    forever begin
      if (run) begin
        #(HALF_NS) clk_o = 1'b1;
        #(HALF_NS) clk_o = 1'b0;
      end else begin
        #1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/sclk_timing_core_test.sv ====
// Self-checking bench for the switching clock and gate timing core
`include "sclk_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module sclk_timing_core_test;
  logic mclk, arst_n, cyc, stb, we, trip, hold, rnd, run, ack, so, oe, pa, pb, ra, rb, sclk, pin;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int n_mismatch, n_tests, seed, n, s, k;
  int rmod [int];
  assign pin = oe ? so : sclk; // Sync net follows whichever side drives it
  sclk_timing_core sclk_timing_core_i (.MCLK(mclk), .ARST_N(arst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .SYNC_I(pin), .SYNC_O(so), .SYNC_OE(oe), .CS_TRIP_I(trip),
    .PRIMARY_DRIVE_A(pa), .PRIMARY_DRIVE_B(pb), .RECT_DRIVE_A(ra), .RECT_DRIVE_B(rb));
  sclk_sync_source sclk_sync_source_i (.run(run), .clk_o(sclk));
  // Timing clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Comparator trip: random level while enabled, else the held level; one driver only
  always @(posedge mclk) begin
    if (rnd) begin
      trip <= ($random(seed) & 1) != 0;
    end else begin
      trip <= hold;
    end
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, int lo, int hi, logic [31:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  function automatic logic sig(int i);
    case (i)
      0: return so;
      1: return pa;
      2: return pb;
      3: return ra;
      default: return rb;
    endcase
  endfunction
  // Expected counts: settings rounded up to whole clock cycles
  function automatic int dead_c(int r);
    return (r == 0) ? 2 : (r * 1000 + 8858 + 6034) / 6035;
  endfunction
  function automatic int on_c(int r);
    return (r * 1000 + 9484 + 6059) / 6060 + 2;
  endfunction
  // One classic cycle: request held until ack is sampled, then released
  task automatic wb(logic [7:0] a, logic w, logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ack !== 1'b1 && i < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 40) begin
      chk("bus answer", 1, 1, 0);
      finish_test();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic [31:0] m;
    logic [31:0] lm;
    wb(a, 1'b1, d, q);
    lm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}}; // Only enabled lanes land
    m = (a == `SCLK_ADR_CTRL) ? 32'h0000000f : (a == `SCLK_ADR_SYNC_HALF) ? 32'h000003ff :
      (a == `SCLK_ADR_DEAD) ? 32'h01ff01ff : (a == `SCLK_ADR_BLANK) ? 32'h000001ff : 32'h0;
    if (m != 32'h0) begin
      rmod[int'(a)] = (((rmod.exists(int'(a)) ? rmod[int'(a)] : 0) & ~lm) | (d & lm)) & m;
    end
  endtask
  task automatic rd(logic [7:0] a);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk("register read", rmod.exists(int'(a)) ? rmod[int'(a)] : 0, rmod.exists(int'(a)) ?
      rmod[int'(a)] : 0, q);
  endtask
  task automatic wt(int i, logic v, output int c);
    c = 0;
    while (sig(i) !== v) begin
      @(posedge mclk);
      c++;
      if (c > 6000) begin
        chk("wait bound", 0, 0, c);
        finish_test();
      end
    end
  endtask
  // Length of the next whole high run, or gap from a fall of i to a rise of j
  task automatic pulse(int i, output int c);
    wt(i, 1'b0, c);
    wt(i, 1'b1, c);
    wt(i, 1'b0, c);
  endtask
  task automatic gap(int i, int j, output int c);
    wt(i, 1'b1, c);
    wt(i, 1'b0, c);
    wt(j, 1'b1, c);
  endtask
  initial begin
    arst_n = 1'b0;
    {cyc, stb, we, hold, rnd, run, adr, wdat} = '0;
    sel = 4'hf;
    seed = 74;
    rmod[`SCLK_ADR_CTRL] = `SCLK_CTRL_RST;
    rmod[`SCLK_ADR_SYNC_HALF] = `SCLK_SYNC_HALF_RST;
    rmod[`SCLK_ADR_BLANK] = `SCLK_BLANK_RST;
    rmod[`SCLK_ADR_STATUS] = 32'h0000000c; // Internal mode, idle, phase on its last quarter
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset image, an unmapped word, random dead settings read back
    for (k = 0; k < 24; k += 4) begin
      rd(k[7:0]);
    end
    wr(8'h14, 32'hffffffff);
    rd(8'h14);
    repeat (3) begin
      wr(`SCLK_ADR_DEAD, $random(seed));
      rd(`SCLK_ADR_DEAD);
    end
    // Low half-word only: the rectifier-to-primary field must survive the write
    sel <= 4'h3;
    wr(`SCLK_ADR_DEAD, $random(seed));
    sel <= 4'hf;
    rd(`SCLK_ADR_DEAD);
    wr(`SCLK_ADR_DEAD, 32'h0);
    // Internal clock: sync output half period, clamped at both ends
    rnd <= 1'b1;
    wr(`SCLK_ADR_CTRL, 32'h9);
    for (k = 10; k < 700; k += 290) begin
      wr(`SCLK_ADR_SYNC_HALF, k);
      pulse(0, n);
      chk("sync half period", k < 25 ? 25 : (k > 500 ? 500 : k), k < 25 ? 25 : (k > 500 ? 500 : k),
        n);
    end
    // Every duty limit: the second pair runs only at half limit
    wr(`SCLK_ADR_SYNC_HALF, 25);
    for (k = 0; k < 3; k++) begin
      wr(`SCLK_ADR_CTRL, 32'h9 | (k << 1));
      repeat (200) @(posedge mclk);
      for (s = 2; s < 5; s += 2) begin
        n = 0;
        repeat (600) @(posedge mclk) n += int'(sig(s) === 1'b1);
        chk("second pair active", k == 0, k == 0, n != 0);
      end
    end
    wr(`SCLK_ADR_CTRL, 32'h1);
    repeat (200) @(posedge mclk);
    n = 0;
    s = 0;
    repeat (600) @(posedge mclk) begin
      n += int'(ra === 1'b1 || rb === 1'b1);
      s += int'(pa === 1'b1);
    end
    chk("rectifier held off", 0, 0, n);
    chk("primary switching", 1, 600, s);
    // Trip held: pulse width is the blanking minimum, gaps are the dead times
    rnd <= 1'b0;
    @(posedge mclk);
    hold <= 1'b1;
    wr(`SCLK_ADR_SYNC_HALF, 250);
    for (k = 10; k <= 300; k += 290) begin
      wr(`SCLK_ADR_BLANK, k);
      wr(`SCLK_ADR_CTRL, 32'h5);
      pulse(1, n);
      chk("primary on time", on_c(k), on_c(k) + 1, n);
    end
    wr(`SCLK_ADR_CTRL, 32'h9);
    for (k = 0; k <= 60; k += 60) begin
      wr(`SCLK_ADR_DEAD, k | (k << 16));
      gap(1, 3, n);
      chk("primary to rectifier gap", dead_c(k), dead_c(k) + 1, n);
      gap(3, 1, n);
      chk("rectifier to primary gap", dead_c(k), dead_c(k) + 1, n);
    end
    // External clock: pin turns input, switching at half the applied rate, stops on loss
    wr(`SCLK_ADR_DEAD, 32'h0);
    wr(`SCLK_ADR_BLANK, 10);
    rnd <= 1'b1;
    wr(`SCLK_ADR_CTRL, 32'h8);
    chk("sync pin driven", 0, 0, oe);
    run <= 1'b1;
    repeat (100) @(posedge mclk);
    pulse(1, n);
    wt(1, 1'b1, s);
    chk("external switching period", 19, 20, n + s);
    run <= 1'b0;
    repeat (2100) @(posedge mclk);
    chk("outputs after clock loss", 0, 0, {pa, pb, ra, rb});
    finish_test();
  end
endmodule
bind sclk_timing_core sclk_timing_core_checker sclk_timing_core_checker_i (.MCLK(MCLK),
  .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .SYNC_I(SYNC_I), .SYNC_OE(SYNC_OE), .PRIMARY_DRIVE_A(PRIMARY_DRIVE_A),
  .PRIMARY_DRIVE_B(PRIMARY_DRIVE_B), .RECT_DRIVE_A(RECT_DRIVE_A), .RECT_DRIVE_B(RECT_DRIVE_B));
`default_nettype wire
